/* verilog/spi_pio_params.svh */
// Offsets, field positions, reset values of the serial PIO block
// Included by the block; holds definitions only
`ifndef SPI_PIO_PARAMS_SVH
`define SPI_PIO_PARAMS_SVH
// ========================================
// Register offsets
`define OFS_DIV 8'h00
`define OFS_MODE 8'h04
`define OFS_CSMODE 8'h18
`define OFS_DLY0 8'h28
`define OFS_DLY1 8'h2C
`define OFS_FMT 8'h40
`define OFS_TXQ 8'h48
`define OFS_RXQ 8'h4C
`define OFS_TXMARK 8'h50
`define OFS_STAT 8'h78
// ========================================
// Field positions
`define LEAD_LSB 0
`define TAIL_LSB 16
`define IDLE_LSB 0
`define GAP_LSB 16
`define PROTO_LSB 0
`define ENDIAN_BIT 2
`define DIR_BIT 3
`define LEN_LSB 16
`define FLAG_BIT 31
// ========================================
// Reset values
`define RST_DIV 12'h003
`define RST_LEAD 8'h01
`define RST_TAIL 8'h01
`define RST_IDLE 8'h01
`define RST_GAP 8'h00
`define RST_LEN 4'h8
`endif

/* verilog/spi_pio_pkg.sv */
// Types of the serial PIO block
// Offsets and reset values live in spi_pio_params.svh
package spi_pio_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LEAD = 3'h1,
        ST_GAP = 3'h2,
        ST_SHIFT = 3'h3,
        ST_TAIL = 3'h4,
        ST_REST = 3'h5
    } state_e;
    typedef enum logic [1:0] {
        LN_SINGLE = 2'h0,
        LN_DUAL = 2'h1,
        LN_QUAD = 2'h2,
        LN_RSVD = 2'h3
    } lane_e;
    typedef enum logic [1:0] {
        CS_AUTO = 2'h0,
        CS_ONE = 2'h1,
        CS_HOLD = 2'h2,
        CS_SOFT = 2'h3
    } csmode_e;
    typedef struct packed {
        logic [11:0] div;
        logic [7:0] lead;
        logic [7:0] tail;
        logic [7:0] idle;
        logic [7:0] gap;
        lane_e proto;
        logic endian;
        logic dir;
        logic [3:0] len;
        logic [2:0] mark;
        logic pha;
        logic pol;
        csmode_e csmode;
    } cfg_s;
    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [31:0] wdata;
    } bus_req_s;
endpackage

/* verilog/spi_pio.sv */
// Serial PIO controller: delays, frame format, tx/rx queues
// Assumes a one-cycle register port master and slaves on four lanes
//
// Functional notes
// - All chip-select and frame delays counted in whole serial clock periods.
// - Lead delay after select before first leading edge; plus half if phase 0.
// - Tail delay after last trailing edge before select release; resets to one.
// - Phase 1 adds half a period to the tail delay.
// - Select stays inactive at least the idle gap count; resets to one.
// - Frame gap between frames only in held and software select modes.
// - Frame bit count takes 0 through 8, resets to 8.
// - Reset format single lane, MSB first, 8 bits; direction per flash option.
// - Lane select: 0 single, 1 dual, 2 quad; unused lanes released.
// - Bit order 0 sends MSB first, 1 sends LSB first.
// - Receive direction releases all lanes in dual/quad; single still drives lane0.
// - Transmit direction never pushes received frames into the rx queue.
// - Write to tx port queues its low eight bits.
// - Tx port bit 31 reads full; writes while full are dropped.
// - Tx port data field always reads zero.
// - Reading rx port dequeues one frame into the low eight bits.
// - Short rx frames aligned high for MSB first, low for LSB first.
// - Rx port bit 31 reads empty; data then not valid.
// - Writes to the rx port are ignored.
// - Three-bit tx threshold resets to 1 with flash option, else 0.
// - Tx low flag while queue holds fewer entries than threshold.
// - Phase 0 samples leading, shifts trailing; phase 1 the reverse.
// - Held mode keeps select after first frame; mode 3 never asserts select, only releases it.
// - Serial clock is bus clock over twice the sum of divisor and one.
`timescale 1ns/1ps
`include "spi_pio_params.svh"

module spi_pio #(
    parameter bit FLASH_EN = 1'b1,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire spi_pio_pkg::bus_req_s req,
    output logic [31:0] rdata,
    // Serial side
    output logic sck_o,
    output logic cs_n_o,
    input wire logic [3:0] lane_i,
    output logic [3:0] lane_o,
    output logic [3:0] lane_oe_n,
    // Status
    output logic tx_low_o,
    output logic busy_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    typedef struct packed {
        spi_pio_pkg::cfg_s cfg;
        spi_pio_pkg::state_e st;
        logic [DEPTH-1:0][7:0] txm;
        logic [DEPTH-1:0][7:0] rxm;
        logic [AW-1:0] txw;
        logic [AW-1:0] txr;
        logic [AW-1:0] rxw;
        logic [AW-1:0] rxr;
        logic [CW-1:0] txn;
        logic [CW-1:0] rxn;
        logic [11:0] hcnt;
        logic [8:0] dly;
        logic [3:0] per;
        logic ph;
        logic first;
        logic cs_act;
        logic drop;
        logic [7:0] tsr;
        logic [7:0] rsr;
        logic [31:0] rdata;
    } core_s;

    localparam spi_pio_pkg::cfg_s CFG_RST = '{
        div: `RST_DIV, lead: `RST_LEAD, tail: `RST_TAIL,
        idle: `RST_IDLE, gap: `RST_GAP,
        proto: spi_pio_pkg::LN_SINGLE, endian: 1'b0, dir: FLASH_EN,
        len: `RST_LEN, mark: {2'b00, FLASH_EN}, pha: 1'b0, pol: 1'b0,
        csmode: spi_pio_pkg::CS_AUTO
    };

    core_s s;
    core_s n;
    logic tick;
    logic tx_full;
    logic rx_empty;
    logic push_tx;
    logic pop_tx;
    logic push_rx;
    logic pop_rx;
    logic [3:0] step;
    logic [3:0] per_cnt;
    logic [3:0] rx_bits;
    logic [7:0] rx_val;
    logic [7:0] tx_head;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    // ========================================
    // Lane and frame arithmetic
    always_comb begin
        tx_full = (s.txn == CW'(DEPTH));
        rx_empty = (s.rxn == '0);
        tx_head = s.txm[s.txr];
        case (s.cfg.proto)
            spi_pio_pkg::LN_DUAL: begin
                step = 4'h2;
                per_cnt = (s.cfg.len + 4'h1) >> 1;
            end
            spi_pio_pkg::LN_QUAD: begin
                step = 4'h4;
                per_cnt = (s.cfg.len + 4'h3) >> 2;
            end
            default: begin
                step = 4'h1;
                per_cnt = s.cfg.len;
            end
        endcase
        rx_bits = per_cnt * step;
    end

    // ========================================
    // Next-state logic
    always_comb begin
        n = s;
        push_tx = 1'b0;
        pop_tx = 1'b0;
        push_rx = 1'b0;
        pop_rx = 1'b0;
        rx_val = '0;
        n.rdata = '0;
        tick = (s.hcnt >= s.cfg.div);
        n.hcnt = tick ? 12'h000 : s.hcnt + 12'h001;

        case (s.st)
            spi_pio_pkg::ST_IDLE: begin
                if (!s.cs_act) begin
                    n.drop = 1'b0;
                end
                if (s.cs_act && (s.cfg.csmode != spi_pio_pkg::CS_HOLD || s.drop)) begin
                    n.cs_act = 1'b0;
                    n.drop = 1'b0;
                    n.st = spi_pio_pkg::ST_REST;
                    n.dly = {s.cfg.idle, 1'b0};
                    n.hcnt = '0;
                end else if (s.txn != '0 && (s.cfg.dir || s.rxn != CW'(DEPTH))) begin
                    pop_tx = 1'b1;
                    n.tsr = s.cfg.endian ? rev8(tx_head) : tx_head;
                    n.first = 1'b1;
                    n.ph = 1'b0;
                    n.per = per_cnt;
                    n.hcnt = '0;
                    if (s.cs_act || s.cfg.csmode == spi_pio_pkg::CS_SOFT) begin
                        n.st = spi_pio_pkg::ST_GAP;
                        n.dly = {s.cfg.gap, 1'b0};
                    end else begin
                        n.cs_act = 1'b1;
                        n.st = spi_pio_pkg::ST_LEAD;
                        n.dly = {s.cfg.lead, 1'b0} + {8'h00, ~s.cfg.pha};
                    end
                end
            end
            spi_pio_pkg::ST_LEAD, spi_pio_pkg::ST_GAP: begin
                if (s.dly == '0) begin
                    n.st = spi_pio_pkg::ST_SHIFT;
                    n.hcnt = '0;
                end else if (tick) begin
                    n.dly = s.dly - 9'h001;
                end
            end
            spi_pio_pkg::ST_SHIFT: begin
                if (s.per == '0) begin
                    rx_val = (s.rsr << (4'h8 - rx_bits)) & (8'hFF << (4'h8 - s.cfg.len));
                    if (!s.cfg.dir && s.rxn != CW'(DEPTH)) begin
                        push_rx = 1'b1;
                    end
                    n.hcnt = '0;
                    if (s.cs_act && s.cfg.csmode != spi_pio_pkg::CS_HOLD) begin
                        n.st = spi_pio_pkg::ST_TAIL;
                        n.dly = {s.cfg.tail, 1'b0} + {8'h00, s.cfg.pha};
                    end else begin
                        n.st = spi_pio_pkg::ST_IDLE;
                    end
                end else if (tick) begin
                    if (!s.ph) begin
                        n.ph = 1'b1;
                        n.first = 1'b0;
                        if (!s.cfg.pha) begin
                            n.rsr = sample(s.rsr);
                        end else if (!s.first) begin
                            n.tsr = s.tsr << step;
                        end
                    end else begin
                        n.ph = 1'b0;
                        n.per = s.per - 4'h1;
                        if (!s.cfg.pha) begin
                            n.tsr = s.tsr << step;
                        end else begin
                            n.rsr = sample(s.rsr);
                        end
                    end
                end
            end
            spi_pio_pkg::ST_TAIL: begin
                if (s.dly == '0) begin
                    n.cs_act = 1'b0;
                    n.st = spi_pio_pkg::ST_REST;
                    n.dly = {s.cfg.idle, 1'b0};
                    n.hcnt = '0;
                end else if (tick) begin
                    n.dly = s.dly - 9'h001;
                end
            end
            spi_pio_pkg::ST_REST: begin
                if (s.dly == '0) begin
                    n.st = spi_pio_pkg::ST_IDLE;
                end else if (tick) begin
                    n.dly = s.dly - 9'h001;
                end
            end
            default: begin
                n.st = spi_pio_pkg::ST_IDLE;
            end
        endcase

        // Register writes
        if (req.we) begin
            if (req.addr == `OFS_DIV) begin
                n.cfg.div = req.wdata[11:0];
            end else if (req.addr == `OFS_MODE) begin
                n.cfg.pha = req.wdata[0];
                n.cfg.pol = req.wdata[1];
            end else if (req.addr == `OFS_CSMODE) begin
                n.cfg.csmode = spi_pio_pkg::csmode_e'(req.wdata[1:0]);
                if (req.wdata[1:0] != s.cfg.csmode) begin
                    n.drop = 1'b1;
                end
            end else if (req.addr == `OFS_DLY0) begin
                n.cfg.lead = req.wdata[`LEAD_LSB +: 8];
                n.cfg.tail = req.wdata[`TAIL_LSB +: 8];
            end else if (req.addr == `OFS_DLY1) begin
                n.cfg.idle = req.wdata[`IDLE_LSB +: 8];
                n.cfg.gap = req.wdata[`GAP_LSB +: 8];
            end else if (req.addr == `OFS_FMT) begin
                n.cfg.proto = spi_pio_pkg::lane_e'(req.wdata[`PROTO_LSB +: 2]);
                n.cfg.endian = req.wdata[`ENDIAN_BIT];
                n.cfg.dir = req.wdata[`DIR_BIT];
                n.cfg.len = req.wdata[`LEN_LSB+3] ? 4'h8 : req.wdata[`LEN_LSB +: 4];
            end else if (req.addr == `OFS_TXQ) begin
                push_tx = !tx_full;
            end else if (req.addr == `OFS_TXMARK) begin
                n.cfg.mark = req.wdata[2:0];
            end
        end

        // Register reads
        if (req.re) begin
            if (req.addr == `OFS_DIV) begin
                n.rdata = {20'h00000, s.cfg.div};
            end else if (req.addr == `OFS_MODE) begin
                n.rdata = {30'h00000000, s.cfg.pol, s.cfg.pha};
            end else if (req.addr == `OFS_CSMODE) begin
                n.rdata = {30'h00000000, s.cfg.csmode};
            end else if (req.addr == `OFS_DLY0) begin
                n.rdata = {8'h00, s.cfg.tail, 8'h00, s.cfg.lead};
            end else if (req.addr == `OFS_DLY1) begin
                n.rdata = {8'h00, s.cfg.gap, 8'h00, s.cfg.idle};
            end else if (req.addr == `OFS_FMT) begin
                n.rdata = {12'h000, s.cfg.len, 12'h000, s.cfg.dir, s.cfg.endian, s.cfg.proto};
            end else if (req.addr == `OFS_TXQ) begin
                n.rdata = {tx_full, 31'h00000000};
            end else if (req.addr == `OFS_RXQ) begin
                n.rdata = {rx_empty, 23'h000000, s.rxm[s.rxr]};
                pop_rx = !rx_empty;
            end else if (req.addr == `OFS_TXMARK) begin
                n.rdata = {29'h00000000, s.cfg.mark};
            end else if (req.addr == `OFS_STAT) begin
                n.rdata = {30'h00000000, busy_o, tx_low_o};
            end
        end

        if (push_tx) begin
            n.txm[s.txw] = req.wdata[7:0];
            n.txw = s.txw + AW'(1);
        end
        if (pop_tx) begin
            n.txr = s.txr + AW'(1);
        end
        n.txn = s.txn + CW'(push_tx) - CW'(pop_tx);
        if (push_rx) begin
            n.rxm[s.rxw] = s.cfg.endian ? rev8(rx_val) : rx_val;
            n.rxw = s.rxw + AW'(1);
        end
        if (pop_rx) begin
            n.rxr = s.rxr + AW'(1);
        end
        n.rxn = s.rxn + CW'(push_rx) - CW'(pop_rx);
    end

    function automatic logic [7:0] sample(input logic [7:0] v);
        case (s.cfg.proto)
            spi_pio_pkg::LN_DUAL: return {v[5:0], lane_i[1:0]};
            spi_pio_pkg::LN_QUAD: return {v[3:0], lane_i};
            default: return {v[6:0], lane_i[1]};
        endcase
    endfunction

    // ========================================
    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.cfg <= CFG_RST;
        end else begin
            s <= n;
        end
    end

    // ========================================
    // Outputs
    always_comb begin
        rdata = s.rdata;
        sck_o = s.cfg.pol ^ s.ph;
        cs_n_o = ~s.cs_act;
        busy_o = (s.st != spi_pio_pkg::ST_IDLE);
        tx_low_o = ({1'b0, s.txn} < (CW+1)'(s.cfg.mark));
        case (s.cfg.proto)
            spi_pio_pkg::LN_DUAL: begin
                lane_o = {2'b00, s.tsr[7:6]};
                lane_oe_n = s.cfg.dir ? 4'b1100 : 4'b1111;
            end
            spi_pio_pkg::LN_QUAD: begin
                lane_o = s.tsr[7:4];
                lane_oe_n = s.cfg.dir ? 4'b0000 : 4'b1111;
            end
            default: begin
                lane_o = {3'b000, s.tsr[7]};
                lane_oe_n = 4'b1110;
            end
        endcase
    end

    // ========================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence txq_wr;
        req.we && req.addr == `OFS_TXQ;
    endsequence
    sequence rxq_rd;
        req.re && req.addr == `OFS_RXQ;
    endsequence

    a_tx_full_drop: assert property (
        txq_wr ##0 tx_full |=> s.txn <= $past(s.txn))
        else $error("write while full changed tx count");
    a_tx_enqueue: assert property (
        txq_wr ##0 (!tx_full && s.st != spi_pio_pkg::ST_IDLE)
        |=> s.txn == $past(s.txn) + 1)
        else $error("tx write not queued");
    a_tx_read_zero: assert property (
        req.re && req.addr == `OFS_TXQ |=> rdata[7:0] == 8'h00 && rdata[31] == $past(tx_full))
        else $error("tx port read data not zero");
    a_rx_dequeue: assert property (
        rxq_rd ##0 (!rx_empty && s.st != spi_pio_pkg::ST_SHIFT)
        |=> s.rxn == $past(s.rxn) - 1)
        else $error("rx read did not dequeue");
    a_rx_empty_flag: assert property (
        rxq_rd ##0 rx_empty |=> rdata[31] && s.rxn <= 1)
        else $error("empty flag missing");
    a_rx_tx_dir: assert property (
        s.cfg.dir |=> s.rxn <= $past(s.rxn))
        else $error("rx queue filled in transmit direction");
    a_rx_wr_ignore: assert property (
        req.we && req.addr == `OFS_RXQ |=> s.rxn >= $past(s.rxn))
        else $error("rx port write popped data");
    a_cs_rest_idle: assert property (
        s.st == spi_pio_pkg::ST_REST |-> cs_n_o && sck_o == s.cfg.pol)
        else $error("select active during idle gap");
    a_zero_lead: assert property (
        s.st == spi_pio_pkg::ST_LEAD && s.dly == '0 |=> s.st == spi_pio_pkg::ST_SHIFT)
        else $error("zero delay not skipped");
    a_no_empty_start: assert property (
        s.st == spi_pio_pkg::ST_IDLE && s.txn == '0
        |=> s.st != spi_pio_pkg::ST_LEAD && s.st != spi_pio_pkg::ST_GAP)
        else $error("frame started with empty tx queue");
endmodule

/* test/spi_slave_model.sv */
// Behavioural serial slave on lane0/lane1, clock mode 0
// Assumes the controller drives sck and an active-low select
`timescale 1ns/1ps

module spi_slave_model (
    // Serial side
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    // Test side
    input wire logic [7:0] resp,
    output logic [7:0] got,
    output int frames
);
    logic [7:0] out_sh;
    logic [7:0] in_sh;
    initial begin
        miso = 1'b0;
        got = 8'h00;
        frames = 0;
        out_sh = 8'h00;
        in_sh = 8'h00;
    end
    // ========================================
    // Shift and sample
    // first bit on select
    always @(negedge cs_n) begin
        out_sh = resp;
        miso = resp[7];
        in_sh = 8'h00;
    end
    always @(posedge sck) if (!cs_n) in_sh = {in_sh[6:0], mosi};
    always @(negedge sck) if (!cs_n) begin
        out_sh = {out_sh[6:0], 1'b0};
        miso = out_sh[7];
    end
    // Released line shows inverse of last bit
    always @(posedge cs_n) begin
        got = in_sh;
        frames++;
        miso = ~miso;
    end
endmodule

/* test/spi_pio_tb.sv */
// Register-level testbench of the serial PIO block
// Assumes a serial slave model on lane0/lane1 and FLASH_EN set
`timescale 1ns/1ps
`include "spi_pio_params.svh"

module spi_pio_tb;
    logic clk;
    logic rst;
    spi_pio_pkg::bus_req_s req;
    logic [31:0] rdata;
    logic sck_o, cs_n_o, tx_low_o, busy_o, miso, seen_rise;
    logic [3:0] lane_o, lane_oe_n;
    logic [7:0] resp, got;
    int frames, fr, n0, l0, t0, g0;
    int miscompares = 0;
    int num_checks = 0;
    int n_csf = 0;
    time t_csf, t_rise, t_fall, t_csr, t_gap, t_lr;
    logic [7:0] ra [5] = '{`OFS_DLY0, `OFS_DLY1, `OFS_TXMARK, `OFS_FMT, 8'h44};
    logic [31:0] rw [5] = '{32'h0005_0004, 32'h0002_0003, 32'h0000_0005, 32'h000F_0008,
                            32'h0000_0005};
    logic [31:0] rx [5] = '{32'h0005_0004, 32'h0002_0003, 32'h0000_0005, 32'h0008_0008,
                            32'h0000_0000};
    logic [31:0] xf [4] = '{32'h0008_000C, 32'h0008_0000, 32'h0004_0000, 32'h0004_0004};
    logic [7:0] xd [4] = '{8'h01, 8'h01, 8'h10, 8'h08};
    logic [7:0] xg [4] = '{8'h80, 8'h01, 8'h01, 8'h01};
    logic [31:0] xm [4] = '{32'h8000_0000, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
    logic [31:0] xr [4] = '{32'h8000_0000, 32'h0000_00A5, 32'h0000_00A0, 32'h0000_0005};
    int tt [4][7] = '{'{1, 1, 1, 0, 0, 0, 0}, '{3, 2, 3, 0, 200, 100, 200},
                      '{0, 0, 1, 0, -100, -100, 0}, '{1, 1, 1, 1, -50, 50, 0}};
    logic [3:0] oe [2][3] = '{'{4'hE, 4'hF, 4'hF}, '{4'hE, 4'hC, 4'h0}};
    logic [3:0] lo [3] = '{4'h1, 4'h3, 4'hF};

    spi_pio #(.FLASH_EN(1'b1), .DEPTH(8)) u_spi_pio (.clk(clk), .rst(rst), .req(req),
        .rdata(rdata), .sck_o(sck_o), .cs_n_o(cs_n_o), .lane_i({2'b11, miso, 1'b1}),
        .lane_o(lane_o), .lane_oe_n(lane_oe_n), .tx_low_o(tx_low_o), .busy_o(busy_o));
    spi_slave_model u_spi_slave_model (.sck(sck_o), .cs_n(cs_n_o), .mosi(lane_o[0]),
        .miso(miso), .resp(resp), .got(got), .frames(frames));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    // ========================================
    // Edge timestamps of the serial side
    always @(negedge cs_n_o) begin
        t_gap = $time - t_csr;
        t_csf = $time;
        seen_rise = 1'b0;
        n_csf++;
    end
    always @(posedge sck_o) begin
        t_lr = $time;
        if (!seen_rise) begin
            t_rise = $time;
            seen_rise = 1'b1;
        end
    end
    always @(negedge sck_o) t_fall = $time;
    always @(posedge cs_n_o) t_csr = $time;

    // ========================================
    // Bus and check tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.we <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk);
        req.re <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    task automatic wait_idle();
        int quiet;
        quiet = 0;
        for (int i = 0; i < 20000 && quiet < 4; i++) begin
            @(posedge clk);
            quiet = (busy_o === 1'b0) ? quiet + 1 : 0;
        end
        chk(32'(quiet), 32'h0000_0004);
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #(80000 * 50);
        miscompares++;
        end_of_test();
    end

    // ========================================
    // Test sequence
    initial begin
        rst = 1'b1;
        req = '0;
        resp = 8'hA5;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1 chk({31'h0, tx_low_o}, 32'h0000_0001);
        rd_chk(`OFS_DIV, 32'hFFFF_FFFF, 32'h0000_0003);
        rd_chk(`OFS_DLY0, 32'hFFFF_FFFF, 32'h0001_0001);
        rd_chk(`OFS_DLY1, 32'hFFFF_FFFF, 32'h0000_0001);
        rd_chk(`OFS_FMT, 32'hFFFF_FFFF, 32'h0008_0008);
        rd_chk(`OFS_TXMARK, 32'hFFFF_FFFF, 32'h0000_0001);
        rd_chk(`OFS_TXQ, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_chk(`OFS_RXQ, 32'h8000_0000, 32'h8000_0000);
        for (int i = 0; i < 5; i++) begin
            wr(ra[i], rw[i]);
            rd_chk(ra[i], 32'hFFFF_FFFF, rx[i]);
        end
        wr(`OFS_RXQ, 32'h0000_0012);
        rd_chk(`OFS_RXQ, 32'h8000_0000, 32'h8000_0000);
        $display("test registers done");
        wr(`OFS_DLY0, 32'h0001_0001);
        wr(`OFS_DLY1, 32'h0000_0001);
        wr(`OFS_TXMARK, 32'h0000_0007);
        wr(`OFS_DIV, 32'h0000_00FF);
        fr = frames;
        for (int i = 1; i <= 10; i++) wr(`OFS_TXQ, 32'(i));
        rd_chk(`OFS_TXQ, 32'hFFFF_FFFF, 32'h8000_0000);
        chk({31'h0, tx_low_o}, 32'h0000_0000);
        wr(`OFS_DIV, 32'h0000_0000);
        wait_idle();
        chk(32'(frames - fr), 32'h0000_0009);
        chk({24'h0, got}, 32'h0000_0009);
        chk({31'h0, tx_low_o}, 32'h0000_0001);
        rd_chk(`OFS_RXQ, 32'h8000_0000, 32'h8000_0000);
        $display("test fill done");
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_FMT, xf[i]);
            wr(`OFS_TXQ, {24'h0, xd[i]});
            wait_idle();
            chk({24'h0, got}, {24'h0, xg[i]});
            rd_chk(`OFS_RXQ, xm[i], xr[i]);
            rd_chk(`OFS_RXQ, 32'h8000_0000, 32'h8000_0000);
        end
        $display("test format done");
        wr(`OFS_FMT, 32'h0008_0008);
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_DLY0, {8'h0, 8'(tt[i][1]), 8'h0, 8'(tt[i][0])});
            wr(`OFS_DLY1, 32'(tt[i][2]));
            wr(`OFS_MODE, 32'(tt[i][3]));
            wr(`OFS_TXQ, 32'h0000_0055);
            wr(`OFS_TXQ, 32'h0000_0055);
            wait_idle();
            if (i == 0) begin
                l0 = int'(t_rise - t_csf);
                t0 = int'(t_csr - t_fall);
                g0 = int'(t_gap);
            end
            chk(32'(int'(t_rise - t_csf) - l0), 32'(tt[i][4]));
            chk(32'(int'(t_csr - t_fall) - t0), 32'(tt[i][5]));
            chk(32'(int'(t_gap) - g0), 32'(tt[i][6]));
        end
        wr(`OFS_MODE, 32'h0000_0000);
        $display("test delays done");
        wr(`OFS_CSMODE, 32'h0000_0002);
        n0 = n_csf;
        wr(`OFS_TXQ, 32'h0000_0011);
        wr(`OFS_TXQ, 32'h0000_0022);
        wait_idle();
        chk(32'(n_csf - n0), 32'h0000_0001);
        chk({31'h0, cs_n_o}, 32'h0000_0000);
        wr(`OFS_CSMODE, 32'h0000_0003);
        repeat (8) @(posedge clk);
        n0 = n_csf;
        wr(`OFS_TXQ, 32'h0000_0033);
        wait_idle();
        chk({31'h0, cs_n_o}, 32'h0000_0001);
        chk(32'(n_csf - n0), 32'h0000_0000);
        wr(`OFS_CSMODE, 32'h0000_0000);
        $display("test select modes done");
        wr(`OFS_DIV, 32'h0000_0002);
        for (int d = 0; d < 2; d++) begin
            for (int p = 0; p < 3; p++) begin
                wr(`OFS_FMT, {12'h0, 4'h8, 12'h0, 1'(d), 1'b0, 2'(p)});
                wr(`OFS_TXQ, 32'h0000_00F0);
                repeat (3) @(posedge clk);
                #1 chk({28'h0, lane_oe_n}, {28'h0, oe[d][p]});
                chk({28'h0, lane_o}, {28'h0, lo[p]});
                wait_idle();
            end
        end
        chk(32'(t_fall - t_lr), 32'h0000_0096);
        wr(`OFS_MODE, 32'h0000_0002);
        #1 chk({31'h0, sck_o}, 32'h0000_0001);
        rd_chk(`OFS_STAT, 32'hFFFF_FFFF, 32'h0000_0001);
        $display("test lanes done");
        end_of_test();
    end
endmodule
